/* core/cct16_sync.sv */
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module cct16_sync
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // raw pin
   input  wire logic pin_i,
   // filtered level and edges
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic [2:0] stage;
   logic       level_d;

   // ==========================================================
   // synchroniser chain; stage 0 only feeds stage 1
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stage <= 3'h0;
      else
         stage <= {stage[1:0], pin_i};
   end

   // level moves only when stages one and two agree
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         level_o <= 1'b0;
      else if (stage[1] == stage[2])
         level_o <= stage[2];
   end

   // delayed copy for edge detection
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         level_d <= 1'b0;
      else
         level_d <= level_o;
   end

   assign rise_o = level_o & ~level_d;
   assign fall_o = ~level_o & level_d;
endmodule
`default_nettype wire

/* core/cct16_timer.sv */
// 16-bit capture/compare timer with toggle output and wishbone registers
// Operation
// - interval: period match raises period interrupt
// - external clock: count first trigger rises
// - software capture copies counter for reading
// - pulse mode: duty/period matches invert flop
// - buffered duty loads on period match
// - flop set/clear picks output polarity
// - first trigger rise captures into first
// - optional flop invert on first capture
// - mode 11: companion flop edges capture
// - mode 10: trigger rise/fall capture both
// - first interrupt on fall in mode 10
// - second trigger rise captures, second interrupt
`timescale 1ns/10ps
`default_nettype none
module cct16_timer
#(
   parameter int WIDTH = 16
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // wishbone slave
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [7:0]       adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic      [31:0]      dat_o,
   output logic                  ack_o,
   // external pins
   input  wire logic             first_trigger_input_i,
   input  wire logic             second_trigger_input_i,
   input  wire logic             companion_timer_flop_i,
   input  wire logic             prescale_tick_i,
   // outputs
   output logic                  timer_output_pin_o,
   output logic                  irq_o
);
   logic [7:0]       run_control_register;
   logic [7:0]       timer_mode_register;
   logic [5:0]       flop_control_register;
   logic [WIDTH-1:0] duty_compare_register;
   logic [WIDTH-1:0] duty_buffer;
   logic [WIDTH-1:0] period_compare_register;
   logic [WIDTH-1:0] first_capture_register;
   logic [WIDTH-1:0] second_capture_register;
   logic [WIDTH-1:0] up_counter;
   logic [3:0]       status;
   logic [3:0]       mask;
   logic             output_toggle_flop;
   logic             wr;
   logic             rd;
   logic             in0_rise;
   logic             in0_fall;
   logic             in1_rise;
   logic             cmp_rise;
   logic             cmp_fall;
   logic             tick_rise;
   logic             count_en;
   logic             duty_match;
   logic             period_match;
   logic             cap0_load;
   logic             cap1_load;
   logic             cap0_irq;
   logic             swcap;
   logic [1:0]       cpm;
   logic [31:0]      next_rdata;

   // byte-lane merge of a 16-bit register with the write data
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ==========================================================
   // bus front end and synchronised inputs
   cct16_wb u_wb
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cyc_i (cyc_i),
      .stb_i (stb_i),
      .we_i  (we_i),
      .ack_o (ack_o),
      .wr_o  (wr),
      .rd_o  (rd)
   );

   cct16_sync u_in0
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (first_trigger_input_i),
      .level_o (),
      .rise_o  (in0_rise),
      .fall_o  (in0_fall)
   );

   cct16_sync u_in1
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (second_trigger_input_i),
      .level_o (),
      .rise_o  (in1_rise),
      .fall_o  ()
   );

   cct16_sync u_cmp
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (companion_timer_flop_i),
      .level_o (),
      .rise_o  (cmp_rise),
      .fall_o  (cmp_fall)
   );

   // prescaler tick arrives from another block, treated as a pin
   cct16_sync u_tick
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (prescale_tick_i),
      .level_o (),
      .rise_o  (tick_rise),
      .fall_o  ()
   );

   // ==========================================================
   // counting and compare decode
   assign cpm = timer_mode_register[cct16_pkg::MODE_CPM_LSB +: 2];

   // count enable: first trigger rises or prescaler ticks
   // external clock counts trigger rises, prescaler must run
   assign count_en = run_control_register[cct16_pkg::RUN_RUN_BIT]
                   & run_control_register[cct16_pkg::RUN_PRUN_BIT]
                   & ((timer_mode_register[cct16_pkg::MODE_CLK_LSB +: 2] == 2'h0)
                      ? in0_rise : tick_rise);

   assign period_match = count_en & (up_counter == period_compare_register);
   assign duty_match   = count_en & (up_counter == duty_compare_register);

   assign swcap = wr && adr_i == cct16_pkg::OFF_MODE && sel_i[0]
                  && !dat_i[cct16_pkg::MODE_SWC_BIT];

   assign cap0_load = swcap
                    | ((cpm == cct16_pkg::CPM_IN0R || cpm == cct16_pkg::CPM_IN0RF) & in0_rise)
                    | ((cpm == cct16_pkg::CPM_COMP) & cmp_rise);
   assign cap1_load = ((cpm == cct16_pkg::CPM_IN0RF) & in0_fall)
                    | ((cpm == cct16_pkg::CPM_COMP) & cmp_fall)
                    | in1_rise;
   assign cap0_irq = (cpm == cct16_pkg::CPM_IN0RF) ? in0_fall : in0_rise;

   // ==========================================================
   // up counter; the clear lands on the match tick itself, so a capture
   // never sees the count one past the period
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         up_counter <= '0;
      // a stopped timer holds zero
      else if (!run_control_register[cct16_pkg::RUN_RUN_BIT])
         up_counter <= '0;
      else if (period_match && timer_mode_register[cct16_pkg::MODE_CLR_BIT])
         up_counter <= '0;
      else if (count_en)
         up_counter <= up_counter + 1'b1;
   end

   // ==========================================================
   // capture registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         first_capture_register  <= cct16_pkg::RST_WORD;
         second_capture_register <= cct16_pkg::RST_WORD;
      end
      else
      begin
         if (cap0_load)
            first_capture_register <= up_counter;
         if (cap1_load)
            second_capture_register <= up_counter;
      end
   end

   // ==========================================================
   // compare registers with optional duty double buffer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         duty_compare_register   <= cct16_pkg::RST_WORD;
         duty_buffer             <= cct16_pkg::RST_WORD;
         period_compare_register <= cct16_pkg::RST_WORD;
      end
      else
      begin
         if (wr && adr_i == cct16_pkg::OFF_DUTY)
         begin
            duty_buffer <= merge16(duty_buffer, dat_i, sel_i);
            if (!run_control_register[cct16_pkg::RUN_DBUF_BIT])
               duty_compare_register <= merge16(duty_buffer, dat_i, sel_i);
         end
         // buffered duty moves on period match
         else if (run_control_register[cct16_pkg::RUN_DBUF_BIT] && period_match)
            duty_compare_register <= duty_buffer;
         if (wr && adr_i == cct16_pkg::OFF_PERIOD)
            period_compare_register <= merge16(period_compare_register, dat_i, sel_i);
      end
   end

   // ==========================================================
   // output toggle flop; software set/clear wins over hardware inversion
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         output_toggle_flop <= 1'b0;
      else if (wr && adr_i == cct16_pkg::OFF_FFCTL && sel_i[0]
               && dat_i[1:0] == cct16_pkg::FFC_SET)
         output_toggle_flop <= 1'b1;
      else if (wr && adr_i == cct16_pkg::OFF_FFCTL && sel_i[0]
               && dat_i[1:0] == cct16_pkg::FFC_CLR)
         output_toggle_flop <= 1'b0;
      else if ((wr && adr_i == cct16_pkg::OFF_FFCTL && sel_i[0]
                && dat_i[1:0] == cct16_pkg::FFC_INV)
               ^ (duty_match & flop_control_register[cct16_pkg::FF_E0T_BIT])
               ^ (period_match & flop_control_register[cct16_pkg::FF_E1T_BIT])
               ^ (cap0_load & flop_control_register[cct16_pkg::FF_C0T_BIT])
               ^ (cap1_load & flop_control_register[cct16_pkg::FF_C1T_BIT]))
         output_toggle_flop <= ~output_toggle_flop;
   end

   assign timer_output_pin_o = output_toggle_flop;

   // ==========================================================
   // control registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_control_register  <= cct16_pkg::RST_RUN;
         timer_mode_register   <= cct16_pkg::RST_MODE;
         flop_control_register <= cct16_pkg::RST_FFCTL;
         mask                  <= cct16_pkg::RST_MASK;
      end
      else if (wr && sel_i[0])
      begin
         case (adr_i)
            cct16_pkg::OFF_RUN:   run_control_register <= dat_i[7:0];
            // software capture bit self-returns to one
            cct16_pkg::OFF_MODE:  timer_mode_register <= dat_i[7:0]
                                     | (8'h01 << cct16_pkg::MODE_SWC_BIT);
            // command field always reads as 11
            cct16_pkg::OFF_FFCTL: flop_control_register <= {dat_i[5:2], 2'h3};
            cct16_pkg::OFF_MASK:  mask <= dat_i[3:0];
            default:              mask <= mask;
         endcase
      end
   end

   // ==========================================================
   // sticky status; events win over the read-clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status <= 4'h0;
      else
      begin
         // only bits that the read returned are cleared: an event landing in
         // the wait state, after the read data was registered, stays pending
         status <= ((rd && adr_i == cct16_pkg::OFF_STATUS) ? (status & ~dat_o[3:0]) : status)
                 | {in1_rise, cap0_irq, duty_match, period_match};
      end
   end

   assign irq_o = |(status & mask);

   // ==========================================================
   // read mux; unmapped reads return zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (adr_i)
         cct16_pkg::OFF_RUN:    next_rdata[7:0]  = run_control_register;
         cct16_pkg::OFF_MODE:   next_rdata[7:0]  = timer_mode_register;
         cct16_pkg::OFF_FFCTL:  next_rdata[5:0]  = flop_control_register;
         cct16_pkg::OFF_DUTY:   next_rdata[15:0] = duty_buffer;
         cct16_pkg::OFF_PERIOD: next_rdata[15:0] = period_compare_register;
         cct16_pkg::OFF_CAP0:   next_rdata[15:0] = first_capture_register;
         cct16_pkg::OFF_CAP1:   next_rdata[15:0] = second_capture_register;
         cct16_pkg::OFF_STATUS: next_rdata[4:0]  = {output_toggle_flop, status};
         cct16_pkg::OFF_MASK:   next_rdata[3:0]  = mask;
         cct16_pkg::OFF_COUNT:  next_rdata[15:0] = up_counter;
         default:               next_rdata = 32'h0000_0000;
      endcase
   end

   // read data registered while the request waits for ack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h0000_0000;
      else
         dat_o <= next_rdata;
   end
endmodule
`default_nettype wire

/* core/cct16_wb.sv */
// classic wishbone slave front end: one-wait-state ack and strobes
`timescale 1ns/10ps
`default_nettype none
module cct16_wb
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   output logic             ack_o,
   // access strobes, one cycle, with the ack
   output logic             wr_o,
   output logic             rd_o
);
   logic req;

   assign req = cyc_i & stb_i;

   // ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= req & ~ack_o;
   end

   // access takes effect on the edge that samples ack
   assign wr_o = ack_o & req & we_i;
   assign rd_o = ack_o & req & ~we_i;
endmodule
`default_nettype wire

/* shared/cct16_pkg.sv */
// package for the 16-bit capture/compare timer: offsets, fields, reset values
package cct16_pkg;
   // ==========================================================
   // register word offsets (byte addresses)
   localparam logic [7:0] OFF_RUN     = 8'h00;
   localparam logic [7:0] OFF_MODE    = 8'h04;
   localparam logic [7:0] OFF_FFCTL   = 8'h08;
   localparam logic [7:0] OFF_DUTY    = 8'h0C;
   localparam logic [7:0] OFF_PERIOD  = 8'h10;
   localparam logic [7:0] OFF_CAP0    = 8'h14;
   localparam logic [7:0] OFF_CAP1    = 8'h18;
   localparam logic [7:0] OFF_STATUS  = 8'h1C;
   localparam logic [7:0] OFF_MASK    = 8'h20;
   localparam logic [7:0] OFF_COUNT   = 8'h24;
   // ==========================================================
   // run register fields
   localparam int RUN_RUN_BIT  = 0;
   localparam int RUN_PRUN_BIT = 2;
   localparam int RUN_DBUF_BIT = 7;
   // mode register fields
   localparam int MODE_CLK_LSB = 0;   // 2 bits: 00 external, else internal
   localparam int MODE_CLR_BIT = 2;   // clear on period match
   localparam int MODE_CPM_LSB = 3;   // 2 bits capture mode
   localparam int MODE_SWC_BIT = 5;   // write 0 = software capture
   // flop control fields
   localparam int FF_CMD_LSB   = 0;   // 00 invert 01 set 10 clear 11 none
   localparam int FF_E0T_BIT   = 2;   // invert on duty match
   localparam int FF_E1T_BIT   = 3;   // invert on period match
   localparam int FF_C0T_BIT   = 4;   // invert on capture into first
   localparam int FF_C1T_BIT   = 5;   // invert on capture into second
   // status bits
   localparam int ST_PERIOD    = 0;
   localparam int ST_DUTY      = 1;
   localparam int ST_CAP0      = 2;
   localparam int ST_CAP1      = 3;
   // ==========================================================
   // capture modes
   localparam logic [1:0] CPM_OFF   = 2'h0;
   localparam logic [1:0] CPM_IN0R  = 2'h1;
   localparam logic [1:0] CPM_IN0RF = 2'h2;
   localparam logic [1:0] CPM_COMP  = 2'h3;
   // flop commands
   localparam logic [1:0] FFC_INV = 2'h0;
   localparam logic [1:0] FFC_SET = 2'h1;
   localparam logic [1:0] FFC_CLR = 2'h2;
   // reset values
   localparam logic [7:0]  RST_RUN   = 8'h00;
   localparam logic [7:0]  RST_MODE  = 8'h20;
   localparam logic [5:0]  RST_FFCTL = 6'h03;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [3:0]  RST_MASK  = 4'h0;
endpackage

/* test/cct16_far.sv */
// far-side model: trigger pins, companion flop and prescale tick source
`timescale 1ns/10ps
`default_nettype none
module cct16_far
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // tick gate
   input  wire logic tick_en_i,
   // pins toward the timer
   output logic      first_o,
   output logic      second_o,
   output logic      comp_o,
   output logic      tick_o
);
   logic [2:0] cnt;
   // tick four high, four low: long enough to pass the pin filter
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt <= 3'h0;
      else
         cnt <= cnt + 3'h1;
   end
   assign tick_o = tick_en_i & cnt[2];
   // pins idle low until a scenario moves them
   initial
   begin
      first_o = 1'b0;
      second_o = 1'b0;
      comp_o = 1'b0;
   end
   // one pin changes just after an edge
   task automatic set_pin(input int which, input logic v);
      @(posedge clk_i);
      case (which)
         0: first_o <= v;
         1: second_o <= v;
         default: comp_o <= v;
      endcase
   endtask
endmodule
`default_nettype wire

/* test/cct16_timer_asserts.sv */
// port-level checker for the capture/compare timer, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module cct16_checker
#(
   parameter int WIDTH = 16
)
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   // outputs
   input  wire logic        timer_output_pin_o,
   input  wire logic        irq_o
);
   // ==========================================================
   // bus handshake: exactly one wait state, one-cycle ack
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_wait: assert property (cyc_i && stb_i && !ack_o && !$past(cyc_i && stb_i) |=> ack_o)
      else $error("ack did not follow request start");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_unmapped_zero: assert property (ack_o && !we_i && adr_i > cct16_pkg::OFF_COUNT
      |-> dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   // outputs are quiet as reset lets go
   a_reset_quiet: assert property ($fell(rst_i)
      |-> !ack_o && !irq_o && !timer_output_pin_o && dat_o == 32'h0000_0000)
      else $error("outputs not quiet after reset");
   // a zero mask must silence the interrupt at once
   a_mask_off: assert property (ack_o && we_i && adr_i == cct16_pkg::OFF_MASK && sel_i[0]
      && dat_i[3:0] == 4'h0 |=> !irq_o)
      else $error("irq high with all sources masked");
   // software set/clear win over hardware inversion
   a_flop_set: assert property (ack_o && we_i && adr_i == cct16_pkg::OFF_FFCTL && sel_i[0]
      && dat_i[1:0] == cct16_pkg::FFC_SET |-> ##[1:2] timer_output_pin_o)
      else $error("output pin not set by command");
   a_flop_clear: assert property (ack_o && we_i && adr_i == cct16_pkg::OFF_FFCTL && sel_i[0]
      && dat_i[1:0] == cct16_pkg::FFC_CLR |-> ##[1:2] !timer_output_pin_o)
      else $error("output pin not cleared by command");
endmodule
bind cct16_timer cct16_checker #(.WIDTH(WIDTH)) u_cct16_checker (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .timer_output_pin_o(timer_output_pin_o), .irq_o(irq_o));
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic        ack_o, pin, irq, first, second, comp, tick, p0;
   logic        tick_en = 1'b0;
   logic [15:0] q, s1, s2, c0, c1, prev;
   int          failures = 0;
   int          n_checks = 0;
   int          hi, lo, k;
   always #50 clk_i = ~clk_i;
   // ==========================================================
   // design and far side
   cct16_timer u_cct16_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .first_trigger_input_i(first), .second_trigger_input_i(second),
      .companion_timer_flop_i(comp), .prescale_tick_i(tick),
      .timer_output_pin_o(pin), .irq_o(irq));
   cct16_far u_cct16_far (.clk_i(clk_i), .rst_i(rst_i), .tick_en_i(tick_en), .first_o(first),
      .second_o(second), .comp_o(comp), .tick_o(tick));
   // ==========================================================
   // tasks
   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; read data lands in q at the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {16'h0000, d};
      sel_i <= 4'h3;
      i = 0;
      do
      begin
         @(posedge clk_i);
         i++;
      end
      while (ack_o !== 1'b1 && i < 20);
      if (ack_o !== 1'b1)
      begin
         failures++;
         report_and_stop();
      end
      q = dat_o[15:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic measure;
      hi = 0;
      lo = 0;
      repeat (192)
      begin
         @(posedge clk_i);
         if (pin === 1'b1) hi++;
         else lo++;
      end
   endtask
   // ==========================================================
   // scenarios
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, cct16_pkg::OFF_RUN, 16'h0000);
      check("run", {8'h00, cct16_pkg::RST_RUN}, q);
      wb(0, cct16_pkg::OFF_MODE, 16'h0000);
      check("mode", {8'h00, cct16_pkg::RST_MODE}, q);
      wb(0, cct16_pkg::OFF_FFCTL, 16'h0000);
      check("ffctl", {10'h000, cct16_pkg::RST_FFCTL}, q);
      wb(0, cct16_pkg::OFF_MASK, 16'h0000);
      check("mask", {12'h000, cct16_pkg::RST_MASK}, q);
      wb(0, cct16_pkg::OFF_DUTY, 16'h0000);
      check("duty", cct16_pkg::RST_WORD, q);
      wb(0, 8'h30, 16'h0000);
      check("unmapped", 16'h0000, q);
      $display("test reset done");
      // interval with clear on match
      tick_en <= 1'b1;
      wb(1, cct16_pkg::OFF_MODE, 16'h0025);
      wb(1, cct16_pkg::OFF_PERIOD, 16'h0003);
      wb(1, cct16_pkg::OFF_MASK, 16'h0001);
      wb(1, cct16_pkg::OFF_RUN, 16'h0005);
      k = 0;
      while (irq !== 1'b1 && k < 300)
      begin
         @(posedge clk_i);
         k++;
      end
      check("irq_period", 16'h0001, {15'h0, irq});
      if (irq !== 1'b1) report_and_stop();
      wb(0, cct16_pkg::OFF_STATUS, 16'h0000);
      check("status_period", 16'h0001, q & 16'h0001);
      repeat (4)
      begin
         wb(1, cct16_pkg::OFF_MODE, 16'h0005);
         wb(0, cct16_pkg::OFF_CAP0, 16'h0000);
         check("count_in_period", 16'h0000, {15'h0, q > 16'h0003});
      end
      wb(1, cct16_pkg::OFF_MASK, 16'h0000);
      idle(1);
      check("irq_masked", 16'h0000, {15'h0, irq});
      $display("test interval done");
      // event counting on the first trigger
      tick_en <= 1'b0;
      wb(1, cct16_pkg::OFF_RUN, 16'h0000);
      wb(1, cct16_pkg::OFF_MODE, 16'h0020);
      wb(1, cct16_pkg::OFF_RUN, 16'h0005);
      repeat (5)
      begin
         u_cct16_far.set_pin(0, 1'b1);
         idle(10);
         u_cct16_far.set_pin(0, 1'b0);
         idle(10);
      end
      wb(1, cct16_pkg::OFF_MODE, 16'h0000);
      wb(0, cct16_pkg::OFF_CAP0, 16'h0000);
      check("event_count", 16'h0005, q);
      $display("test events done");
      // capture modes 01, 10, 11 with flop inversion on first capture
      tick_en <= 1'b1;
      wb(1, cct16_pkg::OFF_RUN, 16'h0000);
      wb(1, cct16_pkg::OFF_FFCTL, 16'h0013);
      wb(1, cct16_pkg::OFF_MASK, 16'h000C);
      wb(1, cct16_pkg::OFF_RUN, 16'h0005);
      prev = 16'h0000;
      for (k = 1; k < 4; k++)
      begin
         wb(1, cct16_pkg::OFF_MODE, {10'h001, k[1:0], 3'h1});
         wb(0, cct16_pkg::OFF_STATUS, 16'h0000);
         p0 = pin;
         u_cct16_far.set_pin(k == 3 ? 2 : 0, 1'b1);
         idle(12);
         wb(0, cct16_pkg::OFF_STATUS, 16'h0000);
         s1 = q;
         u_cct16_far.set_pin(k == 3 ? 2 : 0, 1'b0);
         idle(12);
         wb(0, cct16_pkg::OFF_STATUS, 16'h0000);
         s2 = q;
         wb(0, cct16_pkg::OFF_CAP0, 16'h0000);
         c0 = q;
         wb(0, cct16_pkg::OFF_CAP1, 16'h0000);
         c1 = q;
         check("int_on_rise", {15'h0, k == 1}, {15'h0, s1[2]});
         check("int_on_fall", {15'h0, k == 2}, {15'h0, s2[2]});
         check("cap0_moved", 16'h0001, {15'h0, c0 != prev});
         if (k > 1) check("cap1_after", 16'h0001, {15'h0, c1 > c0});
         check("flop_inverted", {15'h0, ~p0}, {15'h0, pin});
         prev = c0;
      end
      u_cct16_far.set_pin(1, 1'b1);
      idle(12);
      wb(0, cct16_pkg::OFF_STATUS, 16'h0000);
      check("second_int", 16'h0001, {15'h0, q[3]});
      wb(0, cct16_pkg::OFF_CAP1, 16'h0000);
      check("cap1_second", 16'h0001, {15'h0, q > c1});
      u_cct16_far.set_pin(1, 1'b0);
      $display("test capture done");
      // pulse generation, buffered duty, polarity
      wb(1, cct16_pkg::OFF_RUN, 16'h0000);
      wb(1, cct16_pkg::OFF_FFCTL, 16'h000D);
      idle(2);
      check("flop_set", 16'h0001, {15'h0, pin});
      wb(1, cct16_pkg::OFF_MODE, 16'h0025);
      wb(1, cct16_pkg::OFF_DUTY, 16'h0001);
      wb(1, cct16_pkg::OFF_PERIOD, 16'h0005);
      wb(1, cct16_pkg::OFF_RUN, 16'h0085);
      idle(8);
      measure();
      check("short_high", 16'h0001, {15'h0, lo > hi});
      wb(1, cct16_pkg::OFF_DUTY, 16'h0004);
      idle(60);
      measure();
      check("long_high", 16'h0001, {15'h0, hi > lo});
      wb(1, cct16_pkg::OFF_RUN, 16'h0000);
      wb(1, cct16_pkg::OFF_FFCTL, 16'h000E);
      idle(2);
      check("flop_clear", 16'h0000, {15'h0, pin});
      $display("test pulse done");
      // delayed one-shot: capture, program both compares, stop at period match
      wb(1, cct16_pkg::OFF_FFCTL, 16'h0002);
      wb(1, cct16_pkg::OFF_MODE, 16'h0029);
      wb(1, cct16_pkg::OFF_RUN, 16'h0005);
      idle(8);
      u_cct16_far.set_pin(0, 1'b1);
      idle(6);
      wb(0, cct16_pkg::OFF_CAP0, 16'h0000);
      c0 = q;
      // delay of ten ticks, width of four ticks
      wb(1, cct16_pkg::OFF_DUTY, c0 + 16'h000A);
      wb(1, cct16_pkg::OFF_PERIOD, c0 + 16'h000E);
      wb(1, cct16_pkg::OFF_FFCTL, 16'h000F);
      wb(0, cct16_pkg::OFF_STATUS, 16'h0000);
      check("oneshot_cap_int", 16'h0001, {15'h0, q[2]});
      wb(1, cct16_pkg::OFF_MASK, 16'h0001);
      k = 0;
      hi = 0;
      while (irq !== 1'b1 && k < 400)
      begin
         @(posedge clk_i);
         k++;
         if (pin === 1'b1) hi++;
      end
      check("oneshot_done", 16'h0001, {15'h0, irq});
      // four ticks of eight clocks each
      check("oneshot_width", 16'h0020, hi[15:0]);
      wb(1, cct16_pkg::OFF_FFCTL, 16'h0000);
      idle(2);
      check("flop_invert", 16'h0001, {15'h0, pin});
      u_cct16_far.set_pin(0, 1'b0);
      $display("test oneshot done");
      report_and_stop();
   end
endmodule
`default_nettype wire
